// *** include/pmad_pkg.sv ***
// package: modes, access kinds, data-memory window constants and carriers
package pmad_pkg;

   // operating modes (one-hot)
   typedef enum logic [3:0]
   {
      MODE_MICROPROCESSOR = 4'b0001,
      MODE_MP_BOOT_BLOCK = 4'b0010,
      MODE_MICROCONTROLLER = 4'b0100,
      MODE_EXT_MICROCONTROLLER = 4'b1000
   } pmad_mode_type;

   // encoded selection pins
   localparam logic [1:0] SEL_MICROPROCESSOR = 2'h0;
   localparam logic [1:0] SEL_MP_BOOT_BLOCK = 2'h1;
   localparam logic [1:0] SEL_MICROCONTROLLER = 2'h2;
   localparam logic [1:0] SEL_EXT_MICROCONTROLLER = 2'h3;

   // access kinds
   typedef enum logic [1:0]
   {
      ACC_FETCH = 2'h0,
      ACC_TABLE_READ = 2'h1,
      ACC_TABLE_WRITE = 2'h2
   } pmad_kind_type;

   localparam int PROG_ADDR_WIDTH = 21;
   localparam logic [20:0] INTERNAL_TOP_DEFAULT = 21'h01_FFFF;

   // data memory and register window
   localparam int DATA_ADDR_WIDTH = 12;
   localparam logic [11:0] SFR_WINDOW_LOW = 12'h0F60;
   localparam logic [11:0] SFR_WINDOW_HIGH = 12'h0FFF;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // port h and j register addresses
   localparam logic [11:0] ADDR_PORT_J_DIRECTION = 12'h0F9A;
   localparam logic [11:0] ADDR_PORT_H_DIRECTION = 12'h0F99;
   localparam logic [11:0] ADDR_PORT_J_OUTPUT_LATCH = 12'h0F91;
   localparam logic [11:0] ADDR_PORT_H_OUTPUT_LATCH = 12'h0F90;
   localparam logic [11:0] ADDR_PORT_J_PINS = 12'h0F88;
   localparam logic [11:0] ADDR_PORT_H_PINS = 12'h0F87;
   // locations with no register behind them
   localparam logic [11:0] ADDR_HOLE_0 = 12'h0FD4;
   localparam logic [11:0] ADDR_HOLE_1 = 12'h0F7B;
   localparam logic [11:0] ADDR_HOLE_2 = 12'h0F7A;
   localparam logic [11:0] ADDR_HOLE_3 = 12'h0F61;
   localparam logic [11:0] ADDR_HOLE_4 = 12'h0F60;

   // program access request and answer
   typedef struct packed
   {
      logic valid;
      pmad_kind_type kind;
      logic [20:0] addr;
   } pmad_prog_req_type;

   typedef struct packed
   {
      logic valid;
      logic allow;
      logic to_external;
      logic internal_en;
      logic external_en;
   } pmad_prog_ans_type;

   // register window decode answer
   typedef struct packed
   {
      logic in_window;
      logic implemented;
      logic force_zero;
   } pmad_sfr_ans_type;

endpackage

// *** rtl/pmad_sfr_decode.sv ***
// register window decode: window hit, holes and the port h/j registers
`timescale 1ns/1ps
`default_nettype none
module pmad_sfr_decode
   import pmad_pkg::*;
(
   input wire logic [11:0] addr,
   input wire logic pin_count_64,
   output pmad_sfr_ans_type ans
);

   logic in_window;
   logic is_hole;
   logic is_port_hj;

   // window spans the upper 160 bytes of bank 15
   assign in_window = (addr >= SFR_WINDOW_LOW) && (addr <= SFR_WINDOW_HIGH); // R5
   assign is_hole = (addr == ADDR_HOLE_0) || (addr == ADDR_HOLE_1)
      || (addr == ADDR_HOLE_2) || (addr == ADDR_HOLE_3) || (addr == ADDR_HOLE_4);
   // port h/j registers absent on the small package
   assign is_port_hj = (addr == ADDR_PORT_J_DIRECTION) || (addr == ADDR_PORT_H_DIRECTION)
      || (addr == ADDR_PORT_J_OUTPUT_LATCH) || (addr == ADDR_PORT_H_OUTPUT_LATCH)
      || (addr == ADDR_PORT_J_PINS) || (addr == ADDR_PORT_H_PINS); // R7

   // unimplemented locations read zero
   assign ans.in_window = in_window;
   assign ans.implemented = in_window && !is_hole && !(pin_count_64 && is_port_hj); // R6 R7
   assign ans.force_zero = in_window && !ans.implemented; // R6

endmodule
`default_nettype wire

// *** rtl/pmad_top.sv ***
// program memory mode access decode with register window read masking
//
// Behaviour
// [R1] microprocessor mode: internal memory blocked for all access, external allowed
// [R2] microprocessor with boot block: internal and external both allowed
// [R3] microcontroller mode: internal allowed, every external access denied
// [R4] extended microcontroller: internal and external both allowed
// [R5] register window occupies 0xF60 to 0xFFF, the upper 160 bytes of bank 15
// [R6] unimplemented window locations read zero and hold no storage
// [R7] 64-pin parts lack port h/j direction, latch and pin registers
// [R8] mode selection caught at reset and held constant while running
`timescale 1ns/1ps
`default_nettype none
module pmad_top
   import pmad_pkg::*;
#(
   parameter logic [20:0] INTERNAL_TOP = INTERNAL_TOP_DEFAULT
)
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [1:0] mode_select,
   input wire logic pin_count_64,
   input wire pmad_prog_req_type prog_req,
   output pmad_prog_ans_type prog_ans,
   input wire logic data_rd,
   input wire logic [11:0] data_addr,
   input wire logic [7:0] data_rd_in,
   output logic [7:0] data_rd_out,
   output logic sfr_hit,
   output pmad_mode_type mode
);

   // all state of the block
   typedef struct packed
   {
      logic [1:0] sel_meta;
      logic [1:0] sel_sync;
      logic pc_meta;
      logic pc_sync;
      logic in_reset;
      pmad_mode_type mode;
      logic pin64;
      pmad_prog_ans_type ans;
      logic [7:0] rd_data;
      logic hit;
   } pmad_state_type;

   pmad_state_type state;
   pmad_state_type next_state;
   pmad_sfr_ans_type sfr_ans;
   logic is_internal;
   logic int_ok;
   logic ext_ok;

   pmad_sfr_decode u_sfr
   (
      .addr(data_addr),
      .pin_count_64(state.pin64),
      .ans(sfr_ans)
   );

   assign is_internal = prog_req.addr <= INTERNAL_TOP;

   // permission table; same for fetch, table read and table write
   always_comb
   begin
      int_ok = 1'b0;
      ext_ok = 1'b0;
      unique case (state.mode)
         MODE_MICROPROCESSOR:
         begin
            int_ok = 1'b0; // R1
            ext_ok = 1'b1; // R1
         end
         MODE_MP_BOOT_BLOCK:
         begin
            int_ok = 1'b1; // R2
            ext_ok = 1'b1; // R2
         end
         MODE_MICROCONTROLLER:
         begin
            int_ok = 1'b1; // R3
            ext_ok = 1'b0; // R3
         end
         MODE_EXT_MICROCONTROLLER:
         begin
            int_ok = 1'b1; // R4
            ext_ok = 1'b1; // R4
         end
         default:
         begin
            int_ok = 1'b0;
            ext_ok = 1'b0;
         end
      endcase
   end

   // next state; straps are synchronised first since they come from pins
   always_comb
   begin
      next_state = state;
      next_state.sel_meta = mode_select;
      next_state.sel_sync = state.sel_meta;
      next_state.pc_meta = pin_count_64;
      next_state.pc_sync = state.pc_meta;
      next_state.in_reset = 1'b0;
      // mode latched only in the cycle after reset release, then frozen
      if (state.in_reset)
      begin
         unique case (state.sel_sync)
            SEL_MICROPROCESSOR: next_state.mode = MODE_MICROPROCESSOR; // R8
            SEL_MP_BOOT_BLOCK: next_state.mode = MODE_MP_BOOT_BLOCK; // R8
            SEL_MICROCONTROLLER: next_state.mode = MODE_MICROCONTROLLER; // R8
            default: next_state.mode = MODE_EXT_MICROCONTROLLER; // R8
         endcase
         next_state.pin64 = state.pc_sync; // R7
      end
      // answer one cycle after the request
      next_state.ans.valid = prog_req.valid;
      next_state.ans.to_external = !is_internal;
      next_state.ans.allow = prog_req.valid && (is_internal ? int_ok : ext_ok);
      next_state.ans.internal_en = prog_req.valid && is_internal && int_ok; // R1 R3
      next_state.ans.external_en = prog_req.valid && !is_internal && ext_ok; // R1 R3
      // window reads: holes force zero, no storage behind them
      next_state.hit = data_rd && sfr_ans.in_window; // R5
      if (data_rd && sfr_ans.force_zero)
      begin
         next_state.rd_data = READ_ZERO; // R6
      end
      else if (data_rd)
      begin
         next_state.rd_data = data_rd_in;
      end
      // reset clears everything except in_reset and mode, which it sets, and the strap synchronisers, which keep sampling;
      // clearing them too would hand a stale zero strap to the latch at release
      if (reset)
      begin
         next_state = '0;
         next_state.sel_meta = mode_select;
         next_state.sel_sync = state.sel_meta;
         next_state.pc_meta = pin_count_64;
         next_state.pc_sync = state.pc_meta;
         next_state.in_reset = 1'b1;
         next_state.mode = MODE_MICROCONTROLLER; // safest default, no external access
      end
   end

   // one register stage for the whole state; reset is folded into next_state
   always_ff @(posedge core_clk)
   begin
      state <= next_state;
   end

   assign prog_ans = state.ans;
   assign data_rd_out = state.rd_data;
   assign sfr_hit = state.hit;
   assign mode = state.mode;

   // checks, program side: answer one cycle after the request
   a_mp_blocks_internal: assert property (@(posedge core_clk) disable iff (reset) // R1
      (state.mode == MODE_MICROPROCESSOR && prog_req.valid && is_internal)
      |=> !prog_ans.allow && !prog_ans.internal_en)
      else $error("internal access allowed in microprocessor mode");
   a_mp_allows_ext: assert property (@(posedge core_clk) disable iff (reset) // R1
      (state.mode == MODE_MICROPROCESSOR && prog_req.valid && !is_internal)
      |=> prog_ans.allow && prog_ans.external_en)
      else $error("external access refused in microprocessor mode");
   a_boot_allows_all: assert property (@(posedge core_clk) disable iff (reset) // R2
      (state.mode == MODE_MP_BOOT_BLOCK && prog_req.valid) |=> prog_ans.allow)
      else $error("access denied in boot block mode");
   a_mc_blocks_ext: assert property (@(posedge core_clk) disable iff (reset) // R3
      (state.mode == MODE_MICROCONTROLLER && prog_req.valid)
      |=> (prog_ans.allow == !prog_ans.to_external) && !prog_ans.external_en)
      else $error("microcontroller mode decision wrong");
   a_mc_allows_int: assert property (@(posedge core_clk) disable iff (reset) // R3
      (state.mode == MODE_MICROCONTROLLER && prog_req.valid && is_internal)
      |=> prog_ans.allow && prog_ans.internal_en)
      else $error("internal access refused in microcontroller mode");
   a_emc_allows_all: assert property (@(posedge core_clk) disable iff (reset) // R4
      (state.mode == MODE_EXT_MICROCONTROLLER && prog_req.valid)
      |=> prog_ans.allow && (prog_ans.internal_en != prog_ans.external_en))
      else $error("extended mode decision wrong");
   // a refused access must leave both memory strobes low, whatever the mode
   a_denied_silent: assert property (@(posedge core_clk) disable iff (reset) // R1 R3
      (prog_ans.valid && !prog_ans.allow)
      |-> !prog_ans.internal_en && !prog_ans.external_en)
      else $error("strobe raised for a refused access");
   // checks, data side: read data and hit one cycle after the strobe
   a_window_hit: assert property (@(posedge core_clk) disable iff (reset) // R5
      data_rd |=> sfr_hit == ($past(data_addr) >= SFR_WINDOW_LOW))
      else $error("register window bounds wrong");
   a_window_miss: assert property (@(posedge core_clk) disable iff (reset) // R5
      (data_rd && data_addr < SFR_WINDOW_LOW)
      |=> !sfr_hit && data_rd_out == $past(data_rd_in))
      else $error("read below the register window altered");
   a_hole_zero: assert property (@(posedge core_clk) disable iff (reset) // R6
      (data_rd && data_addr == ADDR_HOLE_0) |=> data_rd_out == READ_ZERO)
      else $error("hole did not read zero");
   a_holes_zero_rest: assert property (@(posedge core_clk) disable iff (reset) // R6
      (data_rd && (data_addr == ADDR_HOLE_1 || data_addr == ADDR_HOLE_2
      || data_addr == ADDR_HOLE_3 || data_addr == ADDR_HOLE_4))
      |=> data_rd_out == READ_ZERO)
      else $error("other hole did not read zero");
   a_port_hj_64: assert property (@(posedge core_clk) disable iff (reset) // R7
      (data_rd && state.pin64 && data_addr == ADDR_PORT_H_PINS)
      |=> data_rd_out == READ_ZERO)
      else $error("port h register present on small package");
   a_port_rest_64: assert property (@(posedge core_clk) disable iff (reset) // R7
      (data_rd && state.pin64 && (data_addr == ADDR_PORT_J_DIRECTION
      || data_addr == ADDR_PORT_H_DIRECTION || data_addr == ADDR_PORT_J_OUTPUT_LATCH
      || data_addr == ADDR_PORT_H_OUTPUT_LATCH || data_addr == ADDR_PORT_J_PINS))
      |=> data_rd_out == READ_ZERO)
      else $error("port h or j register present on small package");
   a_mode_frozen: assert property (@(posedge core_clk) disable iff (reset) // R8
      !$past(state.in_reset) |-> $stable(state.mode))
      else $error("mode changed while running");
   a_pin64_frozen: assert property (@(posedge core_clk) disable iff (reset) // R7
      !$past(state.in_reset) |-> $stable(state.pin64))
      else $error("package size changed while running");
   a_pass_through: assert property (@(posedge core_clk) disable iff (reset) // R7
      (data_rd && data_addr == ADDR_PORT_H_PINS && !state.pin64)
      |=> data_rd_out == $past(data_rd_in))
      else $error("implemented register data lost");

endmodule
`default_nettype wire

// *** testbench/pmad_ext_prog_mem.sv ***
// external program memory model: counts the accesses granted to it
`timescale 1ns/1ps
`default_nettype none
module pmad_ext_prog_mem
   import pmad_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire pmad_prog_ans_type ans,
   output logic [7:0] access_count
);
   // only a granted external strobe reaches this memory, so the count exposes leaks
   always_ff @(posedge core_clk)
   begin
      if (reset)
         access_count <= 8'h00;
      else if (ans.external_en)
         access_count <= access_count + 8'h01;
   end
endmodule
`default_nettype wire

// *** testbench/program_memory_mode_access_decode_bench.sv ***
// bench: mode access decisions, strap hold and register window reads
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin err_total++; \
   $display("CHECK FAILED %0t ns: %s", $time, m); end end
module program_memory_mode_access_decode_bench
   import pmad_pkg::*;
;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [1:0] mode_select = 2'h0;
   logic pin_count_64 = 1'b0;
   pmad_prog_req_type prog_req = '0;
   pmad_prog_ans_type prog_ans;
   logic data_rd = 1'b0;
   logic [11:0] data_addr = 12'h000;
   logic [7:0] data_rd_in = 8'h00;
   logic [7:0] data_rd_out;
   logic sfr_hit;
   pmad_mode_type mode;
   logic [7:0] ext_count;
   int err_total = 0;
   int n_tests = 0;

   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;

   pmad_top #(.INTERNAL_TOP(INTERNAL_TOP_DEFAULT)) i_dut (.core_clk(core_clk), .reset(reset),
      .mode_select(mode_select), .pin_count_64(pin_count_64), .prog_req(prog_req),
      .prog_ans(prog_ans), .data_rd(data_rd), .data_addr(data_addr), .data_rd_in(data_rd_in),
      .data_rd_out(data_rd_out), .sfr_hit(sfr_hit), .mode(mode));

   pmad_ext_prog_mem i_ext (.core_clk(core_clk), .reset(reset), .ans(prog_ans),
      .access_count(ext_count));

   // inputs always move 1 ns after the edge, clear of sampling
   task step;
      @(posedge core_clk);
      #1;
   endtask

   // straps settle well before release; requests wait two edges after it
   task do_reset(input logic [1:0] sel, input logic p64);
      mode_select = sel;
      pin_count_64 = p64;
      reset = 1'b1;
      repeat (5) step();
      reset = 1'b0;
      repeat (2) step();
   endtask

   // expected grant per mode and target
   function automatic logic allowed(input logic [1:0] sel, input logic ext);
      case (sel)
         SEL_MICROPROCESSOR: return ext;
         SEL_MICROCONTROLLER: return !ext;
         default: return 1'b1;
      endcase
   endfunction

   task prog(input pmad_kind_type k, input logic [20:0] a, input logic ok, input logic ext);
      prog_req = '{valid: 1'b1, kind: k, addr: a};
      step();
      `CHK(prog_ans, pmad_prog_ans_type'({1'b1, ok, ext, ok & !ext, ok & ext}), "grant")
   endtask

   task rd(input logic [11:0] a, input logic [7:0] d, input logic hit);
      data_rd = 1'b1;
      data_addr = a;
      data_rd_in = 8'hA5;
      step();
      `CHK({data_rd_out, sfr_hit}, {d, hit}, "window read")
   endtask

   // every mode, every access kind, both sides of the internal boundary
   task test_modes;
      logic [20:0] addrs [4];
      logic ext;
      addrs = '{21'h00_0000, INTERNAL_TOP_DEFAULT, INTERNAL_TOP_DEFAULT + 21'h1, 21'h1F_FFFF};
      for (int s = 0; s < 4; s++)
      begin
         do_reset(2'(s), 1'b0);
         `CHK(mode, pmad_mode_type'(4'h1 << s), "mode after reset")
         for (int k = 0; k < 3; k++)
            for (int i = 0; i < 4; i++)
            begin
               ext = (i > 1);
               prog(pmad_kind_type'(k), addrs[i], allowed(2'(s), ext), ext);
            end
         prog_req.valid = 1'b0;
         step();
         `CHK(ext_count, (s == 2) ? 8'h00 : 8'h06, "external count")
      end
      $display("test_modes done");
   endtask

   // strap moves while running; permissions must not follow it
   task test_hold;
      do_reset(SEL_MICROCONTROLLER, 1'b0);
      mode_select = SEL_MICROPROCESSOR;
      repeat (4) step();
      `CHK(mode, MODE_MICROCONTROLLER, "mode held")
      prog(ACC_FETCH, 21'h1F_FFFF, 1'b0, 1'b1);
      prog(ACC_TABLE_WRITE, 21'h00_0000, 1'b1, 1'b0);
      prog_req.valid = 1'b0;
      $display("test_hold done");
   endtask

   // window edges, holes, and port h/j registers on both package sizes
   task test_window(input logic p64);
      logic [11:0] a [14];
      logic hole;
      a = '{12'hF5F, 12'hF60, 12'hF61, 12'hF7A, 12'hF7B, 12'hFD4, 12'hFFF, 12'hF62,
         ADDR_PORT_J_DIRECTION, ADDR_PORT_H_DIRECTION, ADDR_PORT_J_OUTPUT_LATCH,
         ADDR_PORT_H_OUTPUT_LATCH, ADDR_PORT_J_PINS, ADDR_PORT_H_PINS};
      do_reset(SEL_EXT_MICROCONTROLLER, p64);
      for (int i = 0; i < 14; i++)
      begin
         hole = (i >= 1 && i <= 5) || (p64 && i >= 8);
         rd(a[i], hole ? 8'h00 : 8'hA5, i != 0);
      end
      data_rd = 1'b0;
      data_rd_in = 8'h3C;
      step();
      `CHK({data_rd_out, sfr_hit}, {p64 ? 8'h00 : 8'hA5, 1'b0}, "read data hold")
      $display("test_window done");
   endtask

   task print_verdict;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // main sequence
   initial
   begin
      test_modes();
      test_hold();
      test_window(1'b0);
      test_window(1'b1);
      print_verdict();
   end

   // watchdog, far beyond the 137 cycles the tests need
   initial
   begin
      #20000;
      err_total++;
      $display("CHECK FAILED %0t ns: watchdog", $time);
      print_verdict();
   end
endmodule
`default_nettype wire
